// >>> hdl/flash_page_erase_read_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module flash_page_erase_read_ctrl
  import flash_pkg::*;
(
  input  wire logic       mclk_i,
  input  wire logic       arst_n_i,
  input  wire erase_req_t erase_i,
  input  wire read_req_t  read_i,
  input  wire logic       pipe_select_i,
  input  wire logic [7:0] reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  output logic [31:0]     reg_rdata_o,
  output logic            busy_o,
  output logic [1:0]      status_o,
  output logic            status_valid_o,
  output logic [DW-1:0]   rd_data_o,
  output logic            rd_valid_o,
  output logic            irq_o
);

  // ==========================================================
  // Storage
  logic [DW-1:0]    mem [PAGES*WORDS];
  logic [DW-1:0]    pbuf [WORDS];
  logic [DW-1:0]    bbuf [WORDS];
  logic [3:0]       wcount_reg [PAGES];
  logic [PAGES-1:0] prot_reg;
  logic [PAGES-1:0] ecc_bad_reg;
  logic [PW-1:0]    pbuf_page_reg;
  logic             pbuf_dirty_reg;
  logic [IRQW-1:0]  irq_stat_reg;
  logic [IRQW-1:0]  irq_mask_reg;

  // ==========================================================
  // Erase sequencer state
  erase_state_t     state_reg;
  logic [PW-1:0]    page_reg;
  logic             ow_reg;
  logic             guard_reg;
  logic [WW-1:0]    widx_reg;
  logic             ecc_hit_reg;
  logic             over_reg;
  logic             refuse;
  logic             clear_last;
  logic             done_ok;
  logic             done_err;
  logic [1:0]       end_code;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] r, input logic s);
    hit = s && (a == r);
  endfunction

  // A foreign page in loss mode would drop unsaved buffer data
  assign refuse = prot_reg[page_reg] ||
                  (guard_reg && pbuf_dirty_reg &&
                   (pbuf_page_reg != page_reg));
  assign clear_last = (state_reg == S_CLEAR) && (widx_reg == LAST_WORD);
  assign end_code = ecc_hit_reg ? ST_ECC :
                    over_reg ? ST_WCOUNT :
                    ST_OK;
  assign done_ok = clear_last && (end_code == ST_OK);
  assign done_err = (clear_last && (end_code != ST_OK)) ||
                    ((state_reg == S_CHECK) && refuse);

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_reg <= S_IDLE;
      page_reg <= '0;
      ow_reg <= 1'b0;
      guard_reg <= 1'b0;
      widx_reg <= '0;
      ecc_hit_reg <= 1'b0;
      over_reg <= 1'b0;
    end else begin
      case (state_reg)
        S_IDLE: begin
          if (erase_i.req) begin
            page_reg <= erase_i.page;
            ow_reg <= erase_i.ow_protect;
            guard_reg <= erase_i.loss_guard;
            state_reg <= S_CHECK;
          end
        end
        S_CHECK: begin
          widx_reg <= '0;
          ecc_hit_reg <= ecc_bad_reg[page_reg];
          // Compare before the increment so a saturated counter cannot wrap under
          over_reg <= wcount_reg[page_reg] >= WCOUNT_LIMIT;
          state_reg <= refuse ? S_IDLE : S_CLEAR;
        end
        S_CLEAR: begin
          widx_reg <= widx_reg + 3'h1;
          if (widx_reg == LAST_WORD) begin
            state_reg <= S_IDLE;
          end
        end
        default: begin
          state_reg <= S_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      busy_o <= 1'b0;
      status_o <= ST_OK;
      status_valid_o <= 1'b0;
    end else begin
      busy_o <= (state_reg == S_IDLE) ? erase_i.req : !(clear_last || done_err);
      status_valid_o <= done_ok || done_err;
      if (done_err && !clear_last) begin
        status_o <= ST_NOT_ERASED;
      end else if (clear_last) begin
        status_o <= end_code;
      end
    end
  end

  // ==========================================================
  // Array and wear counters
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (int i = 0; i < PAGES*WORDS; i++) begin
        mem[i] <= BLANK_WORD;
      end
    end else if (state_reg == S_CLEAR) begin
      mem[{page_reg, widx_reg}] <= ERASED_WORD;
    end
  end

  // Counter saturates rather than wrapping back under the limit
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (int i = 0; i < PAGES; i++) begin
        wcount_reg[i] <= '0;
      end
    end else if (clear_last && wcount_reg[page_reg] != WCOUNT_MAX) begin
      wcount_reg[page_reg] <= wcount_reg[page_reg] + WCOUNT_ONE;
    end
  end

  // ==========================================================
  // Read path
  logic [AW-1:0] last_addr_reg;
  logic [AW-1:0] raddr;
  logic [DW-1:0] fetch;
  logic [DW-1:0] s1_data_reg;
  logic          s1_valid_reg;

  assign raddr = read_i.ahead ? last_addr_reg + ADDR_STEP : read_i.addr;

  always_comb begin
    case (read_i.src)
      SRC_ARRAY: fetch = mem[raddr];
      SRC_PBUF:  fetch = pbuf[raddr[WW-1:0]];
      SRC_BBUF:  fetch = bbuf[raddr[WW-1:0]];
      SRC_STAT:  fetch = {21'h00_0000, wcount_reg[raddr[AW-1:WW]],
                          prot_reg[raddr[AW-1:WW]], ecc_bad_reg[raddr[AW-1:WW]],
                          pbuf_dirty_reg, busy_o, status_o, status_valid_o};
      default:   fetch = ERASED_WORD;
    endcase
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      last_addr_reg <= '0;
    end else if (read_i.req) begin
      last_addr_reg <= raddr;
    end
  end

  // Block buffer keeps the last array word read at each word index; page buffer mirrors its page
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (int i = 0; i < WORDS; i++) begin
        bbuf[i] <= ERASED_WORD;
        pbuf[i] <= ERASED_WORD;
      end
    end else begin
      if (read_i.req && read_i.src == SRC_ARRAY) begin
        bbuf[raddr[WW-1:0]] <= fetch;
        if (raddr[AW-1:WW] == pbuf_page_reg) begin
          pbuf[raddr[WW-1:0]] <= fetch;
        end
      end
      if (state_reg == S_CLEAR && page_reg == pbuf_page_reg) begin
        pbuf[widx_reg] <= ERASED_WORD;
      end
    end
  end

  // Pipe select is meant to be static; a change mid-read may merge two answers
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s1_data_reg <= ERASED_WORD;
      s1_valid_reg <= 1'b0;
      rd_data_o <= ERASED_WORD;
      rd_valid_o <= 1'b0;
    end else begin
      s1_data_reg <= fetch;
      s1_valid_reg <= read_i.req && pipe_select_i;
      rd_valid_o <= s1_valid_reg || (read_i.req && !pipe_select_i);
      if (s1_valid_reg) begin
        rd_data_o <= s1_data_reg;
      end else if (read_i.req && !pipe_select_i) begin
        rd_data_o <= fetch;
      end
    end
  end

  // ==========================================================
  // Register port and interrupt
  logic [IRQW-1:0] irq_set;
  logic [IRQW-1:0] irq_clr;

  assign irq_set = {rd_valid_o, done_err, done_ok};
  assign irq_clr = hit(reg_addr_i, RA_IRQ_STAT, reg_wr_i) ? reg_wdata_i[IRQW-1:0] : '0;

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_stat_reg <= '0;
      irq_mask_reg <= '0;
      irq_o <= 1'b0;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
      if (hit(reg_addr_i, RA_IRQ_MASK, reg_wr_i)) begin
        irq_mask_reg <= reg_wdata_i[IRQW-1:0];
      end
      irq_o <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // Hardware protect set wins over a software write in the same cycle
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      prot_reg <= '0;
      ecc_bad_reg <= '0;
      pbuf_page_reg <= '0;
      pbuf_dirty_reg <= 1'b0;
    end else begin
      if (hit(reg_addr_i, RA_PROTECT, reg_wr_i)) begin
        prot_reg <= reg_wdata_i[PAGES-1:0];
      end
      if (done_ok && ow_reg) begin
        prot_reg[page_reg] <= 1'b1;
      end
      if (hit(reg_addr_i, RA_ECC_BAD, reg_wr_i)) begin
        ecc_bad_reg <= reg_wdata_i[PAGES-1:0];
      end
      if (hit(reg_addr_i, RA_PBUF, reg_wr_i)) begin
        pbuf_page_reg <= reg_wdata_i[PW-1:0];
        pbuf_dirty_reg <= reg_wdata_i[PBUF_DIRTY_BIT];
      end
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      reg_rdata_o <= '0;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        RA_IRQ_STAT: reg_rdata_o <= {29'h0000_0000, irq_stat_reg};
        RA_IRQ_MASK: reg_rdata_o <= {29'h0000_0000, irq_mask_reg};
        RA_PROTECT:  reg_rdata_o <= {24'h00_0000, prot_reg};
        RA_ECC_BAD:  reg_rdata_o <= {24'h00_0000, ecc_bad_reg};
        RA_PBUF:     reg_rdata_o <= {23'h00_0000, pbuf_dirty_reg, 5'h00, pbuf_page_reg};
        RA_STATE:    reg_rdata_o <= {29'h0000_0000, busy_o, status_o};
        default:     reg_rdata_o <= '0;
      endcase
    end else begin
      reg_rdata_o <= '0;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!arst_n_i);

  property p_erase_start;
    state_reg == S_IDLE && erase_i.req |=> busy_o && state_reg == S_CHECK;
  endproperty
  a_erase_start: assert property (p_erase_start) else $error("erase not started");

  property p_page_cleared;
    clear_last |=> mem[{page_reg, 3'h0}] == ERASED_WORD && mem[{page_reg, LAST_WORD}] == ERASED_WORD;
  endproperty
  a_page_cleared: assert property (p_page_cleared) else $error("page not cleared");

  property p_ow_sets_protect;
    done_ok && ow_reg |=> prot_reg[$past(page_reg)];
  endproperty
  a_ow_sets_protect: assert property (p_ow_sets_protect) else $error("protect not set");

  property p_protected;
    state_reg == S_CHECK && prot_reg[page_reg] |=> status_o == ST_NOT_ERASED ##0 status_valid_o;
  endproperty
  a_protected: assert property (p_protected) else $error("protected page not refused");

  property p_loss_mode;
    state_reg == S_CHECK && guard_reg && pbuf_dirty_reg && pbuf_page_reg != page_reg
      |=> status_o == ST_NOT_ERASED && !busy_o;
  endproperty
  a_loss_mode: assert property (p_loss_mode) else $error("loss mode not refused");

  property p_wear;
    clear_last && !ecc_hit_reg && over_reg |=> status_o == ST_WCOUNT;
  endproperty
  a_wear: assert property (p_wear) else $error("wear code missing");

  property p_ecc;
    clear_last && ecc_hit_reg |=> status_o == ST_ECC && status_valid_o;
  endproperty
  a_ecc: assert property (p_ecc) else $error("ecc code missing");

  property p_ahead;
    read_i.req && read_i.ahead |=> last_addr_reg == $past(last_addr_reg) + ADDR_STEP;
  endproperty
  a_ahead: assert property (p_ahead) else $error("read-ahead address wrong");

  property p_pipe_latency;
    read_i.req && pipe_select_i |-> ##2 rd_valid_o;
  endproperty
  a_pipe_latency: assert property (p_pipe_latency) else $error("pipe latency wrong");

  property p_flow_latency;
    read_i.req && !pipe_select_i && !s1_valid_reg |=> rd_valid_o && rd_data_o == $past(fetch);
  endproperty
  a_flow_latency: assert property (p_flow_latency) else $error("flow data wrong");

  property p_clean;
    state_reg == S_CHECK && !refuse && !ecc_bad_reg[page_reg] &&
      wcount_reg[page_reg] < WCOUNT_LIMIT |-> ##9 status_o == ST_OK && status_valid_o;
  endproperty
  a_clean: assert property (p_clean) else $error("clean erase not 00");

  property p_bbuf_source;
    read_i.req && !pipe_select_i && !s1_valid_reg && read_i.src == SRC_BBUF
      |=> rd_data_o == bbuf[$past(raddr[WW-1:0])];
  endproperty
  a_bbuf_source: assert property (p_bbuf_source) else $error("block buffer source wrong");

endmodule
`default_nettype wire

// >>> hdl/flash_pkg.sv
// Functional notes
// - Page erase request starts one page erase
// - Erase clears every word of any page it does not refuse
// - Protect and loss guard act as for program
// - Erasing protected page reports status 01
// - Loss mode refuses foreign page, status 01
// - Write count over limit reports status 11 unless page error
// - Uncorrectable page error reports status 10
// - Read array, page, block buffer or status
// - Read-ahead request reads the next word
// - Pipe select changes read data latency
package flash_pkg;

  // ==========================================================
  // Geometry
  localparam int PW = 3;
  localparam int WW = 3;
  localparam int AW = PW + WW;
  localparam int PAGES = 8;
  localparam int WORDS = 8;
  localparam int DW = 32;
  localparam logic [WW-1:0] LAST_WORD = 3'h7;
  localparam logic [AW-1:0] ADDR_STEP = 6'h01;

  // ==========================================================
  // Status codes and read sources
  localparam logic [1:0] ST_OK = 2'h0;
  localparam logic [1:0] ST_NOT_ERASED = 2'h1;
  localparam logic [1:0] ST_ECC = 2'h2;
  localparam logic [1:0] ST_WCOUNT = 2'h3;
  localparam logic [1:0] SRC_ARRAY = 2'h0;
  localparam logic [1:0] SRC_PBUF = 2'h1;
  localparam logic [1:0] SRC_BBUF = 2'h2;
  localparam logic [1:0] SRC_STAT = 2'h3;

  // ==========================================================
  // Data values and wear limit
  localparam logic [DW-1:0] BLANK_WORD = 32'hFFFF_FFFF;
  localparam logic [DW-1:0] ERASED_WORD = 32'h0000_0000;
  localparam logic [3:0] WCOUNT_LIMIT = 4'h9;
  localparam logic [3:0] WCOUNT_MAX = 4'hF;
  localparam logic [3:0] WCOUNT_ONE = 4'h1;

  // ==========================================================
  // Register map
  localparam logic [7:0] RA_IRQ_STAT = 8'h00;
  localparam logic [7:0] RA_IRQ_MASK = 8'h04;
  localparam logic [7:0] RA_PROTECT = 8'h08;
  localparam logic [7:0] RA_ECC_BAD = 8'h0C;
  localparam logic [7:0] RA_PBUF = 8'h10;
  localparam logic [7:0] RA_STATE = 8'h14;
  localparam int IRQW = 3;
  localparam int IRQ_ERASE_OK = 0;
  localparam int IRQ_ERASE_ERR = 1;
  localparam int IRQ_READ = 2;
  localparam int PBUF_DIRTY_BIT = 8;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic          req;
    logic          ow_protect;
    logic          loss_guard;
    logic [PW-1:0] page;
  } erase_req_t;

  typedef struct packed {
    logic          req;
    logic          ahead;
    logic [1:0]    src;
    logic [AW-1:0] addr;
  } read_req_t;

  typedef enum logic [2:0] {
    S_IDLE  = 3'b001,
    S_CHECK = 3'b010,
    S_CLEAR = 3'b100
  } erase_state_t;

endpackage

// >>> verification/fabric_user_model.sv
`timescale 1ns/1ps
`default_nettype none
module fabric_user_model
  import flash_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       busy_i,
  output var  erase_req_t erase_o,
  output var  read_req_t  read_o,
  output var  logic       pipe_o
);
  // ==========================================
  // Request side of the fabric logic
  initial begin
    erase_o = '0;
    read_o  = '0;
    pipe_o  = 1'b0;
  end

  // No queue in the sequencer, so wait for idle
  task automatic start_erase(input logic [PW-1:0] pg, input logic owp, input logic lg);
    int n;
    n = 0;
    while (busy_i !== 1'b0 && n < 40) begin
      @(negedge clk_i);
      n++;
    end
    @(posedge clk_i);
    erase_o <= '{req: 1'b1, ow_protect: owp, loss_guard: lg, page: pg};
    @(posedge clk_i);
    erase_o.req <= 1'b0;
  endtask

  task automatic start_read(input logic [1:0] src, input logic [AW-1:0] a, input logic ah);
    @(posedge clk_i);
    read_o <= '{req: 1'b1, ahead: ah, src: src, addr: a};
    @(posedge clk_i);
    read_o.req <= 1'b0;
  endtask

  // Only changed while no read is in flight
  task automatic set_pipe(input logic p);
    @(posedge clk_i);
    pipe_o <= p;
  endtask
endmodule
`default_nettype wire

// >>> verification/test_flash_page_erase_read_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_mismatch++; \
  $display("Error t=%0t got=%h exp=%h", $time, a, b); end end
module test_flash_page_erase_read_ctrl
  import flash_pkg::*;
;
  logic        mclk_i = 1'b0;
  logic        arst_n_i = 1'b0;
  logic [7:0]  reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0000_0000;
  logic        reg_wr_i = 1'b0;
  logic        reg_rd_i = 1'b0;
  logic [31:0] reg_rdata_o;
  logic        busy_o;
  logic [1:0]  status_o;
  logic        status_valid_o;
  logic [31:0] rd_data_o;
  logic        rd_valid_o;
  logic        irq_o;
  erase_req_t  erase_i;
  read_req_t   read_i;
  logic        pipe_select_i;
  logic [31:0] mem [64];
  logic [7:0]  prot = 8'h00;
  logic [7:0]  ecc = 8'h00;
  int          wc [8] = '{default: 0};
  int          n_mismatch = 0;
  int          cmp_count = 0;
  int          seed = 92808;
  int          la = 0;
  bit          i_dirty = 1'b0;
  logic [1:0]  st = 2'h0;
  logic [31:0] bb [8] = '{default: 32'h0000_0000};
  logic [31:0] a;

  always #12.5 mclk_i = ~mclk_i;

  fabric_user_model i_usr (.clk_i(mclk_i), .busy_i(busy_o), .erase_o(erase_i),
    .read_o(read_i), .pipe_o(pipe_select_i));

  flash_page_erase_read_ctrl i_dut (.mclk_i(mclk_i), .arst_n_i(arst_n_i),
    .erase_i(erase_i), .read_i(read_i), .pipe_select_i(pipe_select_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .busy_o(busy_o),
    .status_o(status_o), .status_valid_o(status_valid_o), .rd_data_o(rd_data_o),
    .rd_valid_o(rd_valid_o), .irq_o(irq_o));

  // ==========================================
  // Closing report and bounded waits
  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic guard(input int n);
    if (n >= 40) begin
      n_mismatch++;
      print_verdict;
    end
  endtask

  // ==========================================
  // Register bus
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    @(posedge mclk_i);
    reg_addr_i  <= ad;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge mclk_i);
    reg_wr_i    <= 1'b0;
  endtask

  task automatic rdr(input logic [7:0] ad, input logic [31:0] e);
    @(posedge mclk_i);
    reg_addr_i <= ad;
    reg_rd_i   <= 1'b1;
    @(posedge mclk_i);
    reg_rd_i   <= 1'b0;
    @(negedge mclk_i);
    `CHK(reg_rdata_o, e)
  endtask

  // ==========================================
  // Erase and read against the reference model
  task automatic erase(input int pg, input logic owp, input logic lg);
    logic [1:0] code;
    int         n;
    code = ST_OK;
    if (prot[pg] || (lg && i_dirty && pg != 1)) code = ST_NOT_ERASED;
    else begin
      if (wc[pg] < 15) wc[pg]++;
      if (ecc[pg]) code = ST_ECC;
      else if (wc[pg] > int'(WCOUNT_LIMIT)) code = ST_WCOUNT;
      for (int w = 0; w < 8; w++) mem[pg * 8 + w] = ERASED_WORD;
      if (owp && code == ST_OK) prot[pg] = 1'b1;
    end
    st = code;
    i_usr.start_erase(pg[2:0], owp, lg);
    n = 1;
    @(negedge mclk_i);
    while (status_valid_o !== 1'b1 && n < 40) begin
      @(negedge mclk_i);
      n++;
    end
    guard(n);
    `CHK(n, (code == ST_NOT_ERASED) ? 2 : 10)
    `CHK(status_o, code)
    `CHK(busy_o, 1'b0)
  endtask

  task automatic rd(input logic [1:0] src, input logic [5:0] ad, input logic ah, input bit chk);
    int          n;
    int          eff;
    logic [31:0] e;
    eff = ah ? ((la + 1) % 64) : int'(ad);
    la = eff;
    case (src)
      SRC_ARRAY: e = mem[eff];
      SRC_BBUF:  e = bb[eff % 8];
      SRC_STAT:  e = {21'h00_0000, 4'(wc[eff / 8]), prot[eff / 8], ecc[eff / 8], i_dirty, 1'b0,
                      st, 1'b0};
      default:   e = ERASED_WORD;
    endcase
    if (src == SRC_ARRAY) bb[eff % 8] = mem[eff];
    i_usr.start_read(src, ad, ah);
    n = 1;
    @(negedge mclk_i);
    while (rd_valid_o !== 1'b1 && n < 40) begin
      @(negedge mclk_i);
      n++;
    end
    guard(n);
    `CHK(n, 1 + int'(pipe_select_i))
    if (chk) `CHK(rd_data_o, e)
  endtask

  // ==========================================
  // Scenarios
  initial begin
    foreach (mem[i]) mem[i] = BLANK_WORD;
    repeat (12) @(posedge mclk_i);
    arst_n_i <= 1'b1;
    rdr(RA_STATE, 32'h0000_0000);
    rdr(RA_PROTECT, 32'h0000_0000);
    rdr(8'h20, 32'h0000_0000);
    // Buffers first, before array reads refill them
    for (int s = 3; s >= 0; s--) rd(s[1:0], 6'h00, 1'b0, 1'b1);
    erase(2, 1'b0, 1'b0);
    for (int p = 0; p < 2; p++) begin
      i_usr.set_pipe(p[0]);
      repeat (6) begin
        a = $random(seed);
        rd(SRC_ARRAY, a[5:0], 1'b0, 1'b1);
      end
      rd(SRC_ARRAY, 6'h17, 1'b0, 1'b1);
      rd(SRC_ARRAY, 6'h00, 1'b1, 1'b1);
      rd(SRC_ARRAY, 6'h3F, 1'b0, 1'b1);
      rd(SRC_ARRAY, 6'h00, 1'b1, 1'b1);
      rd(SRC_BBUF, 6'h10, 1'b0, 1'b1);
    end
    wr(RA_PROTECT, 32'h0000_0010);
    prot = 8'h10;
    erase(4, 1'b0, 1'b0);
    wr(RA_ECC_BAD, 32'h0000_0020);
    ecc = 8'h20;
    erase(5, 1'b0, 1'b0);
    repeat (10) erase(6, 1'b0, 1'b0);
    rd(SRC_STAT, 6'h30, 1'b0, 1'b1);
    wr(RA_PBUF, 32'h0000_0101);
    i_dirty = 1'b1;
    erase(7, 1'b0, 1'b1);
    erase(7, 1'b0, 1'b0);
    erase(0, 1'b1, 1'b0);
    rdr(RA_PROTECT, {24'h00_0000, prot});
    erase(0, 1'b0, 1'b0);
    // Interrupt: raise, clear, then mask out
    wr(RA_IRQ_MASK, 32'h0000_0001);
    wr(RA_IRQ_STAT, 32'h0000_0007);
    erase(3, 1'b0, 1'b0);
    repeat (2) @(negedge mclk_i);
    `CHK(irq_o, 1'b1)
    wr(RA_IRQ_STAT, 32'h0000_0007);
    repeat (2) @(negedge mclk_i);
    `CHK(irq_o, 1'b0)
    wr(RA_IRQ_MASK, 32'h0000_0000);
    erase(3, 1'b0, 1'b0);
    repeat (2) @(negedge mclk_i);
    `CHK(irq_o, 1'b0)
    rdr(RA_IRQ_STAT, 32'h0000_0001);
    print_verdict;
  end
endmodule
`default_nettype wire
